/* include/opmrs_pkg.sv */
// Constants, register map and state type of the operating mode and reset sequencer.
// Assumes a 250 MHz core clock; times are kept in ns and converted here.
package opmrs_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int PUP_T0_NS = 140000;
    localparam int PUP_T1_NS = 4500000;
    localparam int PUP_T2_NS = 18000000;
    localparam int PUP_T3_NS = 72000000;
    localparam int PUP_T4_NS = 288000000;
    // Least times, so round up
    localparam int PUP_CYC0 = (PUP_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUP_CYC1 = (PUP_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUP_CYC2 = (PUP_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUP_CYC3 = (PUP_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUP_CYC4 = (PUP_T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] OST_TICKS = 5'h10;
    localparam logic [TICK_W-1:0] SETTLE_TICKS = 5'h10;
    localparam logic [2:0] PUP_SEL0 = 3'h0;
    localparam logic [2:0] PUP_SEL1 = 3'h1;
    localparam logic [2:0] PUP_SEL2 = 3'h2;
    localparam logic [2:0] PUP_SEL3 = 3'h3;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OSC_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] MODE_ADDR = 4'h2;
    localparam int SEL_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int OP_MODE_FIELD_LO = 2;
    localparam int OP_MODE_FIELD_HI = 3;
    localparam int PD_BIT = 3;
    localparam int TO_BIT = 4;
    localparam logic [1:0] OP_MODE_FIELD_RUN = 2'h0;
    localparam logic [1:0] OP_MODE_FIELD_HALT = 2'h1;
    localparam logic [1:0] OP_MODE_FIELD_STBY = 2'h2;
    localparam logic STOP_RST = 1'b0;
    localparam logic FLAG_RST = 1'b1;
    // Mode status register bit positions
    localparam int MS_NORMAL = 0;
    localparam int MS_SLOW = 1;
    localparam int MS_STBY = 2;
    localparam int MS_HALT = 3;
    localparam int MS_RESET = 4;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_POWERUP,
        ST_OST,
        ST_RUN,
        ST_STANDBY,
        ST_HALT,
        ST_SETTLE
    } opmrs_state_e;
endpackage

/* rtl/opmrs_top.sv */
// Operating mode and reset sequencer: run, slow, standby and halt control,
// wake-up and reset sequencing with timeout and power-down flags.
// Assumes all inputs synchronous to clk; event inputs are one-cycle pulses,
// reset sources and straps are levels; osc_tick pulses once per oscillator cycle.
//
// Overview of operation
// - After reset, start in normal or slow mode per startup strap.
// - Clock select bit 0 picks slow oscillator, 1 picks fast.
// - Mode field code 10b enters standby, 01b enters halt.
// - Sleep instruction enters halt just like the halt code.
// - In slow mode, and in standby with clock select bit 0, the fast oscillator runs unless stop bit set.
// - Slow oscillator runs in normal, slow and standby modes.
// - Standby stops execution and peripherals; timers keep running if enabled.
// - Standby wakes on timers, watchdog, port change, external or low-voltage.
// - After wake-up, clock select bit chooses normal or slow mode.
// - Halt entry clears power-down flag, sets timeout flag, clears watchdog.
// - Halt stops both oscillators, execution and all peripherals.
// - Halt wakes only on watchdog, port change or external interrupt.
// - Halt wake waits 16 oscillator cycles; standby wake waits none.
// - Wake with interrupts enabled branches to vector, else continues.
// - Stop bit write and halt entry are taken in one write.
// - Power-on, low voltage, reset pin or watchdog reset enter reset.
// - Reset sets timeout and power-down flags according to cause and mode.
// - Released reset waits a strap-selected power-up time.
// - Then 16 oscillator cycles of start-up before execution begins.
// - Clock select bit 1 drives system clock from fast oscillator.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module opmrs_top
    import opmrs_pkg::*;
#(
    parameter int PUP_CYCLES0 = PUP_CYC0,
    parameter int PUP_CYCLES1 = PUP_CYC1,
    parameter int PUP_CYCLES2 = PUP_CYC2,
    parameter int PUP_CYCLES3 = PUP_CYC3,
    parameter int PUP_CYCLES4 = PUP_CYC4,
    parameter int CNT_W = 27
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic por_event,
    input wire logic low_voltage_reset,
    input wire logic reset_pin_n,
    input wire logic wdt_timeout,
    input wire logic wdt_reset_mode,
    input wire logic startup_slow,
    input wire logic [2:0] powerup_sel,
    input wire logic osc_tick,
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic irq_enable_instr,
    input wire logic irq_disable_instr,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire logic timer0_overflow,
    input wire logic timer1_underflow,
    input wire logic pb_change,
    input wire logic ext_irq,
    input wire logic low_voltage_detect,
    output logic in_reset,
    output logic cpu_run,
    output logic sys_clk_fast,
    output logic fast_osc_on,
    output logic slow_osc_on,
    output logic timer0_enable,
    output logic timer1_enable,
    output logic periph_enable,
    output logic wdt_clear,
    output logic wake_to_vector,
    output logic wake_next_instr
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (PUP_CYCLES0 < 1 || PUP_CYCLES1 < 1 || PUP_CYCLES2 < 1 ||
            PUP_CYCLES3 < 1 || PUP_CYCLES4 < 1)
        begin : g_chk_min
            $error("power-up counts must be at least one cycle");
        end
        if (CNT_W < 2 || CNT_W > 31 || PUP_CYCLES4 > (2 ** CNT_W) ||
            PUP_CYCLES3 > (2 ** CNT_W))
        begin : g_chk_w
            $error("counter too narrow for power-up counts");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    opmrs_state_e state;
    opmrs_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic high_clock_select;
    logic fast_osc_stop;
    logic [1:0] op_mode_field;
    logic next_sel;
    logic next_stop;
    logic [1:0] next_op_mode_field;
    logic timeout_flag;
    logic powerdown_flag;
    logic next_to;
    logic next_pd;
    logic irq_global_en;
    logic strap_slow;
    logic [2:0] strap_pup;
    logic wake_done;

    // ************************************************************
    // Decode
    // ************************************************************
    wire rst_evt_pwr = por_event | low_voltage_reset;
    wire rst_evt_pin = ~reset_pin_n;
    wire rst_evt_wdt = wdt_timeout & wdt_reset_mode;
    wire rst_evt = rst_evt_pwr | rst_evt_pin | rst_evt_wdt;
    wire from_halt = (state == ST_HALT) || (state == ST_SETTLE);
    wire wdt_int = wdt_timeout & ~wdt_reset_mode;
    wire osc_wr = reg_wr && (reg_addr == OSC_ADDR) && (state == ST_RUN);
    wire [1:0] wr_op_mode_field = reg_wdata[OP_MODE_FIELD_HI:OP_MODE_FIELD_LO];
    wire enter_halt = sleep_instr || (osc_wr && wr_op_mode_field == OP_MODE_FIELD_HALT);
    wire enter_stby = osc_wr && (wr_op_mode_field == OP_MODE_FIELD_STBY) && !sleep_instr;
    // Both timers wake standby only when their run bits let them count
    wire stby_wake = (timer0_overflow & timer0_run) |
                     (timer1_underflow & timer1_run) |
                     wdt_int | pb_change | ext_irq |
                     low_voltage_detect;
    wire halt_wake = wdt_int | pb_change | ext_irq;
    wire tick_last = osc_tick && (cnt == CNT_W'(OST_TICKS - 5'h01));
    wire settle_last = osc_tick && (cnt == CNT_W'(SETTLE_TICKS - 5'h01));
    wire [CNT_W-1:0] pup_last =
        (strap_pup == PUP_SEL0) ? CNT_W'(PUP_CYCLES0 - 1) :
        (strap_pup == PUP_SEL1) ? CNT_W'(PUP_CYCLES1 - 1) :
        (strap_pup == PUP_SEL2) ? CNT_W'(PUP_CYCLES2 - 1) :
        (strap_pup == PUP_SEL3) ? CNT_W'(PUP_CYCLES3 - 1) :
        CNT_W'(PUP_CYCLES4 - 1);
    wire [CNT_W-1:0] cnt_inc = cnt + CNT_W'(1);

    // ************************************************************
    // Mode sequencer
    // ************************************************************
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_sel = high_clock_select;
        next_stop = fast_osc_stop;
        next_op_mode_field = op_mode_field;
        wake_done = 1'b0;
        if (rst_evt)
        begin
            next_state = ST_RESET;
            next_cnt = '0;
            next_stop = STOP_RST;
            next_op_mode_field = OP_MODE_FIELD_RUN;
        end
        else
        begin
            unique case (state)
                ST_RESET:
                begin
                    next_state = ST_POWERUP;
                    next_cnt = '0;
                end
                ST_POWERUP:
                begin
                    if (cnt == pup_last)
                    begin
                        next_state = ST_OST;
                        next_cnt = '0;
                    end
                    else
                    begin
                        next_cnt = cnt_inc;
                    end
                end
                ST_OST:
                begin
                    if (tick_last)
                    begin
                        next_state = ST_RUN;
                        next_sel = ~strap_slow;
                        next_cnt = '0;
                    end
                    else if (osc_tick)
                    begin
                        next_cnt = cnt_inc;
                    end
                end
                ST_RUN:
                begin
                    if (osc_wr)
                    begin
                        // Stop bit and halt code land in the same write
                        next_sel = reg_wdata[SEL_BIT];
                        next_stop = reg_wdata[STOP_BIT];
                        next_op_mode_field = wr_op_mode_field;
                    end
                    if (enter_halt)
                    begin
                        next_state = ST_HALT;
                        next_op_mode_field = OP_MODE_FIELD_HALT;
                    end
                    else if (enter_stby)
                    begin
                        next_state = ST_STANDBY;
                    end
                    else if (osc_wr)
                    begin
                        // Reserved code 11b leaves the device running
                        next_op_mode_field = OP_MODE_FIELD_RUN;
                    end
                end
                ST_STANDBY:
                begin
                    if (stby_wake)
                    begin
                        next_state = ST_RUN;
                        next_op_mode_field = OP_MODE_FIELD_RUN;
                        wake_done = 1'b1;
                    end
                end
                ST_HALT:
                begin
                    if (halt_wake)
                    begin
                        next_state = ST_SETTLE;
                        next_cnt = '0;
                    end
                end
                ST_SETTLE:
                begin
                    if (settle_last)
                    begin
                        next_state = ST_RUN;
                        next_op_mode_field = OP_MODE_FIELD_RUN;
                        next_cnt = '0;
                        wake_done = 1'b1;
                    end
                    else if (osc_tick)
                    begin
                        next_cnt = cnt_inc;
                    end
                end
                default:
                begin
                    next_state = ST_RESET;
                    next_cnt = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Timeout and power-down flags
    // ************************************************************
    always_comb
    begin
        next_to = timeout_flag;
        next_pd = powerdown_flag;
        if (rst_evt_pwr)
        begin
            next_to = 1'b1;
            next_pd = 1'b1;
        end
        else if (rst_evt_pin)
        begin
            if (from_halt)
            begin
                next_to = 1'b1;
                next_pd = 1'b1;
            end
        end
        else if (rst_evt_wdt)
        begin
            next_to = 1'b0;
            next_pd = ~from_halt;
        end
        else if (state == ST_RUN && enter_halt)
        begin
            next_to = 1'b1;
            next_pd = 1'b0;
        end
        else if (watchdog_clear_instr && state == ST_RUN)
        begin
            next_to = 1'b1;
            next_pd = 1'b1;
        end
        else if (wdt_int)
        begin
            // Timeout in interrupt mode still marks the flag
            next_to = 1'b0;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    wire n_run = (next_state == ST_RUN);
    wire n_stby = (next_state == ST_STANDBY);
    wire n_halt = (next_state == ST_HALT);
    wire n_active = n_run || n_stby;
    wire n_rst = (next_state == ST_RESET) || (next_state == ST_POWERUP) ||
                 (next_state == ST_OST);
    // Fast oscillator stays on through reset and halt settling
    wire n_fast_on = !n_halt && (!n_active || next_sel || !next_stop);
    wire n_slow_on = !n_halt;
    wire n_wdt_clr = (state == ST_RUN) && !rst_evt &&
                     (enter_halt || watchdog_clear_instr);
    wire [DATA_W-1:0] osc_rd = {4'h0, op_mode_field, fast_osc_stop,
                                high_clock_select};
    wire [DATA_W-1:0] stat_rd = {3'h0, timeout_flag, powerdown_flag, 3'h0};
    wire is_normal = (state == ST_RUN) && high_clock_select;
    wire is_slow = (state == ST_RUN) && !high_clock_select;
    wire is_reset = (state == ST_RESET) || (state == ST_POWERUP) ||
                    (state == ST_OST);
    wire [DATA_W-1:0] mode_rd = {3'h0, is_reset, from_halt,
                                 (state == ST_STANDBY), is_slow, is_normal};
    wire [DATA_W-1:0] rd_mux = (reg_addr == OSC_ADDR) ? osc_rd :
                               (reg_addr == STAT_ADDR) ? stat_rd :
                               (reg_addr == MODE_ADDR) ? mode_rd :
                               '0;

    // ************************************************************
    // Flip-flops
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_RESET;
            cnt <= '0;
            high_clock_select <= 1'b1;
            fast_osc_stop <= STOP_RST;
            op_mode_field <= OP_MODE_FIELD_RUN;
            timeout_flag <= FLAG_RST;
            powerdown_flag <= FLAG_RST;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            high_clock_select <= next_sel;
            fast_osc_stop <= next_stop;
            op_mode_field <= next_op_mode_field;
            timeout_flag <= next_to;
            powerdown_flag <= next_pd;
        end
    end

    // Straps are followed while reset holds and frozen once it is released
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strap_slow <= 1'b0;
            strap_pup <= PUP_SEL0;
        end
        else if (state == ST_RESET)
        begin
            strap_slow <= startup_slow;
            strap_pup <= powerup_sel;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || rst_evt || irq_disable_instr)
        begin
            irq_global_en <= 1'b0;
        end
        else if (irq_enable_instr)
        begin
            irq_global_en <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            in_reset <= 1'b1;
            cpu_run <= 1'b0;
            sys_clk_fast <= 1'b1;
            fast_osc_on <= 1'b1;
            slow_osc_on <= 1'b1;
            timer0_enable <= 1'b0;
            timer1_enable <= 1'b0;
            periph_enable <= 1'b0;
            wdt_clear <= 1'b0;
            wake_to_vector <= 1'b0;
            wake_next_instr <= 1'b0;
            reg_rdata <= '0;
        end
        else
        begin
            in_reset <= n_rst;
            cpu_run <= n_run;
            sys_clk_fast <= next_sel;
            fast_osc_on <= n_fast_on;
            slow_osc_on <= n_slow_on;
            timer0_enable <= n_active && timer0_run;
            timer1_enable <= n_active && timer1_run;
            periph_enable <= n_run;
            wdt_clear <= n_wdt_clr;
            wake_to_vector <= wake_done && irq_global_en;
            wake_next_instr <= wake_done && !irq_global_en;
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule
`default_nettype wire

/* bench/opmrs_chk.sv */
// Port checker for the operating mode and reset sequencer.
// Assumes opmrs_top port names; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module opmrs_chk
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por_event,
    input wire logic low_voltage_reset,
    input wire logic reset_pin_n,
    input wire logic wdt_timeout,
    input wire logic wdt_reset_mode,
    input wire logic sleep_instr,
    input wire logic pb_change,
    input wire logic ext_irq,
    input wire logic in_reset,
    input wire logic cpu_run,
    input wire logic sys_clk_fast,
    input wire logic fast_osc_on,
    input wire logic slow_osc_on,
    input wire logic periph_enable,
    input wire logic wdt_clear,
    input wire logic wake_to_vector,
    input wire logic wake_next_instr
);
    // ************************************************************
    // Properties
    // ************************************************************
    wire rsrc = por_event | low_voltage_reset | !reset_pin_n | (wdt_timeout & wdt_reset_mode);
    // Slow oscillator is off only while halted
    wire hlt = !slow_osc_on & !in_reset;
    wire hwake = pb_change | ext_irq | wdt_timeout;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_halt_entry;
        sleep_instr && cpu_run && !rsrc |=> hlt && !fast_osc_on && !cpu_run && !periph_enable;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry outputs wrong");
    property p_halt_wdt;
        sleep_instr && cpu_run && !rsrc |=> wdt_clear ##1 !wdt_clear;
    endproperty
    a_halt_wdt: assert property (p_halt_wdt) else $error("watchdog clear pulse wrong");
    property p_halt_hold;
        hlt && !hwake && !rsrc |=> hlt;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake source");
    property p_halt_wake;
        hlt && pb_change && !rsrc |=> (slow_osc_on && !cpu_run) [*8];
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt wake skipped settling");
    property p_reset;
        rsrc |=> in_reset && !cpu_run;
    endproperty
    a_reset: assert property (p_reset) else $error("reset source not obeyed");
    property p_fast_sel;
        cpu_run && sys_clk_fast |-> fast_osc_on;
    endproperty
    a_fast_sel: assert property (p_fast_sel) else $error("fast clock selected but stopped");
    property p_slow_run;
        cpu_run |-> slow_osc_on;
    endproperty
    a_slow_run: assert property (p_slow_run) else $error("slow oscillator off while running");
    property p_periph;
        periph_enable |-> cpu_run;
    endproperty
    a_periph: assert property (p_periph) else $error("peripherals on while stopped");
    property p_wake;
        wake_to_vector || wake_next_instr |-> cpu_run && !(wake_to_vector && wake_next_instr)
            ##1 !wake_to_vector && !wake_next_instr;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse wrong");
    c_sleep: cover property (sleep_instr && cpu_run);
    c_halt_wake: cover property (hlt ##1 !hlt);
    c_vector: cover property (wake_to_vector);
endmodule
bind opmrs_top opmrs_chk u_opmrs_chk (.clk(clk), .rst(rst), .por_event(por_event),
    .low_voltage_reset(low_voltage_reset), .reset_pin_n(reset_pin_n), .wdt_timeout(wdt_timeout),
    .wdt_reset_mode(wdt_reset_mode), .sleep_instr(sleep_instr), .pb_change(pb_change), .ext_irq(ext_irq),
    .in_reset(in_reset), .cpu_run(cpu_run), .sys_clk_fast(sys_clk_fast), .fast_osc_on(fast_osc_on),
    .slow_osc_on(slow_osc_on), .periph_enable(periph_enable), .wdt_clear(wdt_clear),
    .wake_to_vector(wake_to_vector), .wake_next_instr(wake_next_instr));
`default_nettype wire

/* bench/opmrs_top_tb.sv */
// Self-checking bench for the operating mode and reset sequencer.
// Assumes short power-up counts; osc_tick pulses every other cycle.
`timescale 1ns/10ps
`default_nettype none
module opmrs_top_tb;
    import opmrs_pkg::*;
    logic clk, rst, wr, rd, tick, wrm, sslow, t0r, t1r;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] rs, psel;
    logic [9:0] ev;
    logic inr, run, sfast, fon, son, t0e, t1e, pen, wv, wn, wclr;
    int fails = 0;
    int checks = 0;
    int n, k;
    opmrs_top #(.PUP_CYCLES0(5), .PUP_CYCLES1(6), .PUP_CYCLES2(7), .PUP_CYCLES3(8), .PUP_CYCLES4(9),
        .CNT_W(27)) u_opmrs_top (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .por_event(rs[0]), .low_voltage_reset(rs[1]), .reset_pin_n(!rs[2]),
        .wdt_timeout(ev[5]), .wdt_reset_mode(wrm), .startup_slow(sslow), .powerup_sel(psel),
        .osc_tick(tick), .sleep_instr(ev[6]), .watchdog_clear_instr(ev[7]), .irq_enable_instr(ev[8]),
        .irq_disable_instr(ev[9]), .timer0_run(t0r), .timer1_run(t1r), .timer0_overflow(ev[0]),
        .timer1_underflow(ev[1]), .pb_change(ev[2]), .ext_irq(ev[3]), .low_voltage_detect(ev[4]),
        .in_reset(inr), .cpu_run(run), .sys_clk_fast(sfast), .fast_osc_on(fon), .slow_osc_on(son),
        .timer0_enable(t0e), .timer1_enable(t1e), .periph_enable(pen), .wdt_clear(wclr),
        .wake_to_vector(wv), .wake_next_instr(wn));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic close_out();
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // One-cycle pulse on any event or instruction line
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 10'h000;
        #1;
    endtask
    // Bounded: a hang ends the run as a failure
    task automatic wait_run(output int c);
        c = 0;
        while (run !== 1'b1)
        begin
            @(posedge clk);
            #1 c++;
            if (c > 2000)
            begin
                fails++;
                close_out();
            end
        end
    endtask
    task automatic rsrc(input logic [2:0] v, output int c);
        @(posedge clk);
        rs <= v;
        repeat (2) @(posedge clk);
        rs <= 3'h0;
        #1 chk(inr, 1'b1);
        wait_run(c);
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) tick <= rst ? 1'b0 : ~tick;
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {rst, wr, rd, tick, wrm, sslow, t0r, addr, wdata, rs, psel, ev} = '0;
        {rst, t1r} = 2'b11;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_run(n);
        chk(n >= 37 && n <= 39, 1'b1);
        rreg(MODE_ADDR, 8'h01);
        rreg(STAT_ADDR, 8'h18);
        wreg(OSC_ADDR, 8'h00);
        chk({sfast, fon}, 2'b01);
        rreg(MODE_ADDR, 8'h02);
        wreg(OSC_ADDR, 8'h02);
        chk(fon, 1'b0);
        wreg(OSC_ADDR, 8'h01);
        chk({sfast, fon}, 2'b11);
        pulse(10'h100);
        wreg(OSC_ADDR, 8'h09);
        chk({run, pen, son, t0e, t1e}, 5'b00101);
        rreg(MODE_ADDR, 8'h04);
        t1r <= 1'b0;
        pulse(10'h003);
        chk({run, t1e}, 2'b00);
        {t0r, t1r} <= 2'b11;
        for (k = 0; k < 6; k++)
        begin
            if (k > 0)
                wreg(OSC_ADDR, 8'h09);
            pulse(10'h001 << k);
            chk({run, wv, wn}, 3'b110);
            rreg(OSC_ADDR, 8'h01);
        end
        wreg(OSC_ADDR, 8'h00);
        wreg(OSC_ADDR, 8'h08);
        pulse(10'h008);
        rreg(MODE_ADDR, 8'h02);
        wreg(OSC_ADDR, 8'h01);
        pulse(10'h200);
        for (k = 0; k < 6; k++)
        begin
            if (k % 2 == 1)
                wreg(OSC_ADDR, 8'h07);
            else
                pulse(10'h040);
            chk({son, fon, run, t0e, pen, wclr}, 6'h01);
            rreg(STAT_ADDR, 8'h10);
            pulse(10'h001 << k);
            if (k == 0 || k == 1 || k == 4)
            begin
                chk(son, 1'b0);
                pulse(10'h004);
            end
            wait_run(n);
            chk(n >= 31 && n <= 32, 1'b1);
            chk({wn, wv}, 2'b10);
            rreg(OSC_ADDR, k == 0 ? 8'h01 : 8'h03);
        end
        pulse(10'h080);
        rreg(STAT_ADDR, 8'h18);
        pulse(10'h020);
        rreg(STAT_ADDR, 8'h08);
        rsrc(3'h4, n);
        rreg(STAT_ADDR, 8'h08);
        wrm <= 1'b1;
        pulse(10'h020);
        chk(inr, 1'b1);
        wait_run(n);
        rreg(STAT_ADDR, 8'h08);
        pulse(10'h040);
        pulse(10'h020);
        wait_run(n);
        rreg(STAT_ADDR, 8'h00);
        pulse(10'h040);
        rsrc(3'h4, n);
        rreg(STAT_ADDR, 8'h18);
        psel <= 3'h4;
        sslow <= 1'b1;
        rsrc(3'h1, n);
        chk(n >= 41 && n <= 42, 1'b1);
        rreg(MODE_ADDR, 8'h02);
        pulse(10'h040);
        rsrc(3'h2, n);
        rreg(STAT_ADDR, 8'h18);
        close_out();
    end
endmodule
`default_nettype wire
